// ### qsb_sram_top.sv
`timescale 1ns/100ps
`include "qsb_defs.svh"

// How it works
// - Read address is taken on a true-phase edge of the input pair.
// - Write address is taken on a complementary-phase edge.
// - Every read and write moves exactly two words for one address.
// - With the loop on, first read word appears 1.5 cycles after request.
// - With the loop off, first read word appears one cycle after request.
// - A word crosses each data port on every phase edge.
// - Read and write ports run concurrently on separate data buses.
// - Address, selects and write data are registered on input pair edges.
// - Read data leaves through output registers on input pair edges in both modes.
// - Writes complete internally once data is captured; no pulse timing.
// - Separate read and write selects enable each port on its own.
// - A complementary echo clock pair runs aligned with read data.
// - A read returns the newest data, even from a write in flight.
// - Each address holds two words of 9, 18 or 36 bits, in burst order.

module qsb_sram_top #(
    parameter int ADDR_W = `QSB_ADDR_W,
    parameter int DATA_W = `QSB_DATA_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic kclk_true,
    input wire logic single_clock_mode,
    input wire logic out_clk_true,
    input wire logic dll_disable_input,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] write_data,
    input wire qsb_pkg::qsb_word_sel_t unused_word_sel,
    output logic read_valid,
    input wire logic read_ready,
    output logic [DATA_W-1:0] read_data,
    output logic read_buf_ready,
    output logic echo_clk,
    output logic echo_clk_n
);
    import qsb_pkg::*;

    localparam int IDX_W = ADDR_W + 1;
    localparam int DEPTH = 2 ** IDX_W;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [DATA_W-1:0] mem [DEPTH];
    logic dll_off;
    logic rd_cap;
    logic wr_cap;
    logic rd_v_q [`QSB_RD_PIPE];
    logic [ADDR_W-1:0] rd_a_q [`QSB_RD_PIPE];
    qsb_wr_state_t wr_state_q;
    qsb_wr_state_t wr_state_d;
    logic [ADDR_W-1:0] wr_addr_q;
    logic wr_we;
    qsb_word_sel_t wr_word;
    logic [IDX_W-1:0] wr_idx;
    logic ld0;
    logic ld1;
    logic ld_valid;
    qsb_word_sel_t ld_word;
    logic [ADDR_W-1:0] ld_addr;
    logic [IDX_W-1:0] ld_idx;
    logic ld_hit;
    logic [DATA_W-1:0] ld_data;
    logic echo_q;
    logic echo_n_q;

    // ****************************************************************
    // Loop-disable pin
    // ****************************************************************
    // A strap from a pin; filtered so a bounce cannot flip the latency
    qsb_sync3 u_dll_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in(dll_disable_input),
        .level_q(dll_off)
    );

    // ****************************************************************
    // Address capture on the shared bus
    // ****************************************************************
    // Phase picks the port; each port has its own select
    assign rd_cap = kclk_true && !read_port_select_n;
    assign wr_cap = !kclk_true && !write_port_select_n;

    // Read request pipeline; one stage per phase edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `QSB_RD_PIPE; i++) begin
                rd_v_q[i] <= 1'b0;
            end
        end else begin
            rd_v_q[0] <= rd_cap;
            for (int i = 1; i < `QSB_RD_PIPE; i++) begin
                rd_v_q[i] <= rd_v_q[i-1];
            end
        end
    end

    // Address travels with its request; no reset needed on data
    always_ff @(posedge mclk) begin
        rd_a_q[0] <= addr;
        for (int i = 1; i < `QSB_RD_PIPE; i++) begin
            rd_a_q[i] <= rd_a_q[i-1];
        end
    end

    // ****************************************************************
    // Write port
    // ****************************************************************
    // Next state; a new burst may start on the second word's edge
    always_comb begin
        wr_state_d = wr_state_q;
        case (wr_state_q)
            QSB_WR_IDLE: begin
                if (wr_cap) begin
                    wr_state_d = QSB_WR_WORD0;
                end
            end
            QSB_WR_WORD0: begin
                wr_state_d = QSB_WR_WORD1;
            end
            QSB_WR_WORD1: begin
                wr_state_d = wr_cap ? QSB_WR_WORD0 : QSB_WR_IDLE;
            end
            default: begin
                wr_state_d = QSB_WR_IDLE;
            end
        endcase
    end

    // Write state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_state_q <= QSB_WR_IDLE;
        end else begin
            wr_state_q <= wr_state_d;
        end
    end

    // Write address held for the length of the burst
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_addr_q <= '0;
        end else if (wr_cap && wr_state_q != QSB_WR_WORD0) begin
            wr_addr_q <= addr;
        end
    end

    // One word per phase edge, first word first
    assign wr_we = (wr_state_q != QSB_WR_IDLE);
    assign wr_word = (wr_state_q == QSB_WR_WORD1);
    assign wr_idx = {wr_addr_q, wr_word};

    // Self-timed store: the array takes the word on the capturing edge
    always_ff @(posedge mclk) begin
        if (wr_we) begin
            mem[wr_idx] <= write_data;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Latency picks which pipeline stages launch the two words
    always_comb begin
        if (dll_off) begin
            ld0 = rd_v_q[`QSB_LAT_DLL_OFF - 2];
            ld1 = rd_v_q[`QSB_LAT_DLL_OFF - 1];
            ld_addr = ld1 ? rd_a_q[`QSB_LAT_DLL_OFF - 1]
                          : rd_a_q[`QSB_LAT_DLL_OFF - 2];
        end else begin
            ld0 = rd_v_q[`QSB_LAT_DLL_ON - 2];
            ld1 = rd_v_q[`QSB_LAT_DLL_ON - 1];
            ld_addr = ld1 ? rd_a_q[`QSB_LAT_DLL_ON - 1]
                          : rd_a_q[`QSB_LAT_DLL_ON - 2];
        end
    end

    assign ld_valid = ld0 || ld1;
    assign ld_word = ld1;
    assign ld_idx = {ld_addr, ld_word};

    // Forward a word being written this very edge, else the array
    assign ld_hit = wr_we && (wr_idx == ld_idx);
    assign ld_data = ld_hit ? write_data : mem[ld_idx];

    // Output register doubles as a two-entry skid buffer; a stalled
    // receiver keeps words, but the array cannot wait, so watch the ready
    qsb_buf2 #(
        .W(DATA_W)
    ) u_rd_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(ld_valid),
        .in_ready(read_buf_ready),
        .in_data(ld_data),
        .out_valid(read_valid),
        .out_ready(read_ready),
        .out_data(read_data)
    );

    // ****************************************************************
    // Echo clocks
    // ****************************************************************
    // Follow the output pair, or the input pair in single clock mode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            echo_q <= 1'b0;
            echo_n_q <= 1'b1;
        end else begin
            echo_q <= single_clock_mode ? kclk_true : out_clk_true;
            echo_n_q <= single_clock_mode ? !kclk_true : !out_clk_true;
        end
    end

    assign echo_clk = echo_q;
    assign echo_clk_n = echo_n_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_rd_phase: assert property (
        @(posedge mclk) disable iff (rst)
        rd_v_q[0] |-> $past(kclk_true) && !$past(read_port_select_n))
        else $error("read taken off the true phase");

    a_wr_phase: assert property (
        @(posedge mclk) disable iff (rst)
        (wr_state_q == QSB_WR_WORD0) |-> !$past(kclk_true))
        else $error("write taken off the complementary phase");

    a_wr_burst_two: assert property (
        @(posedge mclk) disable iff (rst)
        (wr_cap && wr_state_q == QSB_WR_IDLE) |=> wr_we && !wr_word
        ##1 wr_we && wr_word)
        else $error("write burst is not two words");

    a_lat_dll_on: assert property (
        @(posedge mclk) disable iff (rst)
        (rd_cap && !dll_off && $stable(dll_off))
        |-> ##2 (ld0 && !ld1) ##1 (ld1 && !ld0))
        else $error("read latency wrong with loop on");

    a_lat_dll_off: assert property (
        @(posedge mclk) disable iff (rst)
        (rd_cap && dll_off && $stable(dll_off))
        |-> ##1 (ld0 && !ld1) ##1 (ld1 && !ld0))
        else $error("read latency wrong with loop off");

    a_wr_stored: assert property (
        @(posedge mclk) disable iff (rst)
        wr_we |=> mem[$past(wr_idx)] == $past(write_data))
        else $error("write word not stored");

    a_coherent: assert property (
        @(posedge mclk) disable iff (rst)
        (ld_valid && ld_hit && read_buf_ready && !read_valid)
        |=> read_data == $past(write_data))
        else $error("read missed write in flight");

    a_echo_pair: assert property (
        @(posedge mclk) disable iff (rst)
        echo_clk != echo_clk_n)
        else $error("echo clocks not complementary");

    a_echo_single: assert property (
        @(posedge mclk) disable iff (rst)
        single_clock_mode |=> echo_clk == $past(kclk_true))
        else $error("echo does not follow input pair");

    a_rd_hold: assert property (
        @(posedge mclk) disable iff (rst)
        (read_valid && !read_ready) |=> read_valid && $stable(read_data))
        else $error("stalled read word changed");

    a_rd_refused: assert property (
        @(posedge mclk) disable iff (rst)
        (!kclk_true || read_port_select_n) |=> !rd_v_q[0])
        else $error("read taken without select on true phase");

    a_wr_refused: assert property (
        @(posedge mclk) disable iff (rst)
        (wr_state_q == QSB_WR_IDLE && (kclk_true || write_port_select_n))
        |=> (wr_state_q == QSB_WR_IDLE))
        else $error("write taken without select on complementary phase");

    a_rd_burst_two: assert property (
        @(posedge mclk) disable iff (rst)
        ld0 |=> ld1 && !ld0)
        else $error("read burst is not two words");

    a_rd_array: assert property (
        @(posedge mclk) disable iff (rst)
        (ld_valid && !ld_hit && read_buf_ready && !read_valid)
        |=> read_data == $past(mem[ld_idx]))
        else $error("read word differs from stored word");

    a_echo_out: assert property (
        @(posedge mclk) disable iff (rst)
        !single_clock_mode |=> echo_clk == $past(out_clk_true))
        else $error("echo does not follow output pair");
endmodule

// ### qsb_defs.svh
`ifndef QSB_DEFS_SVH
`define QSB_DEFS_SVH

// ****************************************************************
// Burst and latency figures, counted in clock phases
// ****************************************************************
// One mclk cycle stands for one edge of the input clock pair
`define QSB_BURST_LEN 2
// Read latency of 1.5 cycles is three phases with the loop running
`define QSB_LAT_DLL_ON 3
// Read latency of one cycle is two phases with the loop off
`define QSB_LAT_DLL_OFF 2
// Depth of the read request pipeline, equal to the longest latency
`define QSB_RD_PIPE 3

// ****************************************************************
// Default organisation
// ****************************************************************
`define QSB_ADDR_W 20
`define QSB_DATA_W 18

// ****************************************************************
// Reset values
// ****************************************************************
`define QSB_SYNC_RST 1'b0

`endif

// ### qsb_pkg.sv
package qsb_pkg;
    // Write port progress through its two data words
    typedef enum logic [1:0] {
        QSB_WR_IDLE,
        QSB_WR_WORD0,
        QSB_WR_WORD1
    } qsb_wr_state_t;

    // Position of a word inside its burst
    typedef logic qsb_word_sel_t;
endpackage

// ### qsb_sync3.sv
`timescale 1ns/100ps
`include "qsb_defs.svh"

module qsb_sync3 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ****************************************************************
    // Three stages; the first feeds only the second
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= `QSB_SYNC_RST;
            s2_q <= `QSB_SYNC_RST;
            s3_q <= `QSB_SYNC_RST;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a new level only once two stages agree, as a glitch filter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_q <= `QSB_SYNC_RST;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule

// ### qsb_buf2.sv
`timescale 1ns/100ps

module qsb_buf2 #(
    parameter int W = 18
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] ent_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // ****************************************************************
    // Handshakes
    // ****************************************************************
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Head entry comes straight from a flip-flop
    assign out_data = ent_q[rd_ptr_q];

    // Storage is written only on a push
    always_ff @(posedge mclk) begin
        if (push) begin
            ent_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule

// ### qsb_ctrl_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Memory controller stand-in: clock phase, selects, address, data
// ****************************************************************
module qsb_ctrl_model #(
    parameter int AW = 4,
    parameter int DW = 18
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic stray,
    input wire logic [AW-1:0] rd_a,
    input wire logic [AW-1:0] wr_a,
    input wire logic [DW-1:0] wd0,
    input wire logic [DW-1:0] wd1,
    output logic kclk_true,
    output logic read_port_select_n,
    output logic write_port_select_n,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] write_data
);
    logic [1:0] wcnt_q;
    logic [DW-1:0] wq0_q;
    logic [DW-1:0] wq1_q;

    // Pins move on the falling edge, clear of the capturing edge
    always @(negedge mclk or posedge rst) begin
        if (rst) begin
            kclk_true <= 1'b0;
            read_port_select_n <= 1'b1;
            write_port_select_n <= 1'b1;
            addr <= '0;
            write_data <= '0;
            wcnt_q <= 2'h0;
        end else begin
            kclk_true <= ~kclk_true;
            read_port_select_n <= 1'b1;
            write_port_select_n <= 1'b1;
            // Idle bus inverts its last value, so a stale good value returns every other edge
            addr <= ~addr;
            write_data <= ~write_data;
            // Two data words follow each write capture
            if (wcnt_q == 2'h2) begin
                write_data <= wq0_q;
                wcnt_q <= 2'h1;
            end else if (wcnt_q == 2'h1) begin
                write_data <= wq1_q;
                wcnt_q <= 2'h0;
            end
            if (!kclk_true) begin
                // Next edge is the true phase: read address slot
                if (rd_en) begin
                    read_port_select_n <= 1'b0;
                    addr <= rd_a;
                end
                if (stray) begin
                    write_port_select_n <= 1'b0;
                end
            end else begin
                // Complementary phase: write address slot
                if (wr_en) begin
                    write_port_select_n <= 1'b0;
                    addr <= wr_a;
                    wq0_q <= wd0;
                    wq1_q <= wd1;
                    wcnt_q <= 2'h2;
                end
                if (stray) begin
                    read_port_select_n <= 1'b0;
                end
            end
        end
    end
endmodule

// ### ddr_split_port_burst_sram_tb.sv
`timescale 1ns/100ps

module ddr_split_port_burst_sram_tb;
    import qsb_pkg::*;
    // ************************************************************
    // Stimulus and scoreboard state
    // ************************************************************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rd_en, wr_en, stray, timed, h1, src;
    logic single_clock_mode, out_clk_true, dll_disable_input, read_ready;
    logic [3:0] ra, wa, addr, wa_q;
    logic [17:0] wd0, wd1, write_data, read_data;
    logic kclk_true, read_port_select_n, write_port_select_n;
    logic read_valid, read_buf_ready, echo_clk, echo_clk_n;
    logic [17:0] mem [0:31];
    logic [17:0] exp_d[$];
    logic [4:0] ln_a[$];
    int exp_t[$];
    int ln_t[$];
    int cyc, lat, wph, bad_count, cmp_count;
    logic [15:0] rnd;

    always #10 mclk = ~mclk;

    qsb_ctrl_model #(.AW(4), .DW(18)) qsb_ctrl_model_i (.mclk(mclk),
        .rst(rst), .rd_en(rd_en), .wr_en(wr_en), .stray(stray),
        .rd_a(ra), .wr_a(wa), .wd0(wd0), .wd1(wd1),
        .kclk_true(kclk_true), .read_port_select_n(read_port_select_n),
        .write_port_select_n(write_port_select_n), .addr(addr),
        .write_data(write_data));

    qsb_sram_top #(.ADDR_W(4), .DATA_W(18)) qsb_sram_top_i (.mclk(mclk),
        .rst(rst), .kclk_true(kclk_true),
        .single_clock_mode(single_clock_mode), .out_clk_true(out_clk_true),
        .dll_disable_input(dll_disable_input),
        .read_port_select_n(read_port_select_n),
        .write_port_select_n(write_port_select_n), .addr(addr),
        .write_data(write_data), .unused_word_sel(1'b0),
        .read_valid(read_valid), .read_ready(read_ready),
        .read_data(read_data), .read_buf_ready(read_buf_ready),
        .echo_clk(echo_clk), .echo_clk_n(echo_clk_n));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One op spans both phases, so each slot is offered once
    task automatic op(input logic r, input logic w, input logic s,
                      input logic [3:0] ar, input logic [3:0] aw);
        @(negedge mclk);
        rnd = lfsr_next(rnd);
        wd0 <= {rnd[1:0], rnd};
        single_clock_mode <= rnd[3];
        out_clk_true <= rnd[5];
        rnd = lfsr_next(rnd);
        wd1 <= {rnd[15:14], rnd};
        {rd_en, wr_en, stray, ra, wa} <= {r, w, s, ar, aw};
        @(negedge mclk);
        out_clk_true <= rnd[7];
    endtask

    // Random mix; same address for both ports half the time
    task automatic rand_ops(input int n);
        repeat (n) begin
            rnd = lfsr_next(rnd);
            op(rnd[0], rnd[1], rnd[4:2] == 3'h0, rnd[8:5],
               rnd[13] ? rnd[8:5] : rnd[12:9]);
        end
    endtask

    // ************************************************************
    // Monitor: memory model, read expectations, echo, timeout
    // ************************************************************
    always @(posedge mclk) begin
        if (!rst) begin
            cyc++;
            // Write words land before any read launched at this edge
            if (wph == 1) begin
                mem[{wa_q, 1'b0}] = write_data;
                wph = 2;
            end else if (wph == 2) begin
                mem[{wa_q, 1'b1}] = write_data;
                wph = 0;
            end
            if (!kclk_true && !write_port_select_n) begin
                wa_q = addr;
                wph = 1;
            end
            while (ln_t.size() > 0 && ln_t[0] == cyc) begin
                exp_d.push_back(mem[ln_a[0]]);
                // Launched word is on the head one edge later
                exp_t.push_back(cyc + 1);
                void'(ln_t.pop_front());
                void'(ln_a.pop_front());
            end
            if (kclk_true && !read_port_select_n) begin
                ln_t.push_back(cyc + lat - 1);
                ln_a.push_back({addr, 1'b0});
                ln_t.push_back(cyc + lat);
                ln_a.push_back({addr, 1'b1});
            end
            if (read_valid === 1'b1 && read_ready) begin
                if (exp_d.size() == 0) begin
                    check(32'h0, 32'h1);
                end else begin
                    check(read_data, exp_d[0]);
                    if (timed) check(32'(cyc), 32'(exp_t[0]));
                    void'(exp_d.pop_front());
                    void'(exp_t.pop_front());
                end
            end
            src = single_clock_mode ? kclk_true : out_clk_true;
            // Echo stands one edge behind the selected pair
            if (cyc > 3) begin
                check(echo_clk, h1);
                check(echo_clk_n, !h1);
            end
            h1 = src;
            if (cyc == 2000) begin
                bad_count++;
                final_report();
            end
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rd_en, wr_en, stray, ra, wa, wd0, wd1} = '0;
        {single_clock_mode, out_clk_true, dll_disable_input} = 3'h0;
        read_ready = 1'b1;
        timed = 1'b1;
        lat = 3;
        rnd = 16'hD73A;
        repeat (5) @(posedge mclk);
        #1;
        check(read_valid, 1'b0);
        check(echo_clk, 1'b0);
        check(echo_clk_n, 1'b1);
        @(negedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) op(1'b0, 1'b1, 1'b0, 4'h0, i[3:0]);
        rand_ops(60);
        repeat (4) op(1'b1, 1'b1, 1'b0, 4'h9, 4'h9);
        repeat (4) op(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        // Loop off: pin passes a synchroniser, so let it settle
        dll_disable_input <= 1'b1;
        repeat (8) op(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        lat = 2;
        rand_ops(60);
        repeat (4) op(1'b1, 1'b1, 1'b0, 4'h3, 4'h3);
        repeat (4) op(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        // Receiver stalls; one burst must wait whole in the buffer
        timed = 1'b0;
        read_ready <= 1'b0;
        op(1'b1, 1'b0, 1'b0, 4'h7, 4'h0);
        repeat (3) op(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        check(read_buf_ready, 1'b0);
        check(read_valid, 1'b1);
        read_ready <= 1'b1;
        repeat (3) op(1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        check(32'(exp_d.size()), 32'h0);
        final_report();
    end
endmodule
